/* File: pkg/bdlbuf_defs.vh */
// constants for the byte link controller data buffer and power-mode block
// assumes inclusion by bare name from design files
`ifndef BDLBUF_DEFS_VH
`define BDLBUF_DEFS_VH
// register byte addresses on the ahb-lite slave
`define BDL_ADDR_DATA   8'h00
`define BDL_ADDR_SVEC   8'h04
`define BDL_ADDR_CTRL   8'h08
`define BDL_ADDR_STAT   8'h0c
`define BDL_ADDR_PWR    8'h10
// state vector codes
`define BDL_SV_NONE     8'h00
`define BDL_SV_EOF      8'h04
`define BDL_SV_RX_RESPONSE_BYTE_FLAG    8'h08
`define BDL_SV_RXFULL   8'h0c
`define BDL_SV_TXEMPTY  8'h10
`define BDL_SV_LOSTARB  8'h14
`define BDL_SV_CRC      8'h18
`define BDL_SV_INVALID  8'h1c
`define BDL_SV_WAKE     8'h20
// control register bit positions
`define BDL_CTL_IE      0
`define BDL_CTL_WCM     1
`define BDL_CTL_TX_END_OF_DATA_REQUEST    2
// power register command bits (write one)
`define BDL_PWR_WAIT    0
`define BDL_PWR_STOP    1
// bit counts
`define BDL_BYTE_BITS   4'h8
`define BDL_PAD_BITS    2'h2
`endif

/* File: verif/bdlbuf_core_chk.sv */
// checker: power mode and tx pad relations at the block's ports
// assumes binding onto bdlbuf_core, one clock, sync low reset
`timescale 1ns/1ps
`default_nettype none
`include "bdlbuf_defs.vh"
module bdlbuf_chk (
  input wire logic        sys_clk,
  input wire logic        resetn,
  input wire logic        hsel,
  input wire logic [7:0]  haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic [31:0] hwdata,
  input wire logic        bus_edge_stb,
  input wire logic        rx_frame_ok_stb,
  input wire logic        tx_active,
  input wire logic        tx_bit_val,
  input wire logic        tx_drive_en,
  input wire logic        tx_underrun,
  input wire logic        cpu_nmi,
  input wire logic [1:0]  pwr_mode
);
  logic pw_ff;
  // data phase of a power write; gated by reset so nothing stale survives
  always @(posedge sys_clk) begin
    pw_ff <= resetn && hsel && hready && htrans[1] && hwrite &&
             haddr == `BDL_ADDR_PWR;
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  sequence stop_cmd;
    pw_ff && hwdata[`BDL_PWR_STOP];
  endsequence
  sequence in_stop;
    pwr_mode == 2'b10;
  endsequence
  drive_gate_a: assert property (tx_drive_en == (tx_active && pwr_mode == 2'b00))
    else $error("bus driven outside run mode");
  nmi_cause_a: assert property ($rose(cpu_nmi) |->
    $past(bus_edge_stb) && $past(pwr_mode) == 2'b10)
    else $error("nonmaskable request without stop wake");
  stop_entry_a: assert property (stop_cmd |-> ##[1:2] in_stop)
    else $error("stop command did not enter stop");
  stop_wake_a: assert property (in_stop ##0 bus_edge_stb |-> ##[1:2] cpu_nmi)
    else $error("bus edge in stop did not wake");
  wait_wake_a: assert property (pwr_mode == 2'b01 && rx_frame_ok_stb
    |-> ##[1:2] pwr_mode == 2'b00) else $error("good frame did not end wait");
  pad_ones_a: assert property (tx_underrun && tx_active |-> tx_bit_val)
    else $error("pad bit after underrun not one");
  stop_hold_a: assert property (in_stop ##0 !bus_edge_stb && !pw_ff |=> in_stop)
    else $error("stop left without bus edge");
  wait_hold_a: assert property (pwr_mode == 2'b01 && !rx_frame_ok_stb && !pw_ff
    |=> pwr_mode == 2'b01) else $error("wait left without good frame");
endmodule // bdlbuf_chk
bind bdlbuf_core bdlbuf_chk i_bdlbuf_chk (
  .sys_clk(sys_clk), .resetn(resetn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hready(hready), .hwdata(hwdata),
  .bus_edge_stb(bus_edge_stb), .rx_frame_ok_stb(rx_frame_ok_stb),
  .tx_active(tx_active), .tx_bit_val(tx_bit_val), .tx_drive_en(tx_drive_en),
  .tx_underrun(tx_underrun), .cpu_nmi(cpu_nmi), .pwr_mode(pwr_mode));
`default_nettype wire

/* File: verif/bdlbuf_node.sv */
// far side model: other bus nodes seen through the symbol layer
// assumes one bit strobe every GAP clocks, msb first both ways
`timescale 1ns/1ps
`default_nettype none
module bdlbuf_node #(
  parameter int GAP = 8
) (
  input  wire logic sys_clk,
  input  wire logic resetn,
  input  wire logic tx_active,
  input  wire logic tx_bit_val,
  output var  logic rx_bit_stb,
  output var  logic rx_bit_val,
  output var  logic tx_bit_stb
);
  logic [7:0] tx_seen_ff = 8'h00;
  int         tx_cnt_ff  = 0;
  int         div_ff     = 0;
  initial begin
    rx_bit_stb = 1'b0;
    rx_bit_val = 1'b1;
    tx_bit_stb = 1'b0;
  end
  // take tx bits at a steady symbol pace, keep the last eight
  always @(posedge sys_clk) begin
    tx_bit_stb <= 1'b0;
    if (!resetn) begin
      div_ff    <= 0;
      tx_cnt_ff <= 0;
    end else if (tx_active) begin
      div_ff <= (div_ff == GAP - 1) ? 0 : div_ff + 1;
      if (div_ff == GAP - 1) begin
        tx_bit_stb <= 1'b1;
        tx_seen_ff <= {tx_seen_ff[6:0], tx_bit_val};
        tx_cnt_ff  <= tx_cnt_ff + 1;
      end
    end
  end
  // bytes follow at one byte time; the line flips once a bit is taken
  task automatic send_byte(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      repeat (GAP - 1) @(posedge sys_clk);
      rx_bit_stb <= 1'b1;
      rx_bit_val <= b[i];
      @(posedge sys_clk);
      rx_bit_stb <= 1'b0;
      rx_bit_val <= ~b[i];
    end
  endtask
endmodule // bdlbuf_node
`default_nettype wire

/* File: verif/test_bdlbuf_core.sv */
// testbench: rx, tx, vector priority and power modes over ahb-lite
// assumes the node model on the far side and a zero wait slave
`timescale 1ns/1ps
`default_nettype none
`include "bdlbuf_defs.vh"
module test_bdlbuf_core;
  logic        sys_clk = 1'b0, resetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [7:0]  haddr = 8'h00;
  logic [1:0]  htrans = 2'b00, pwr_mode;
  logic [2:0]  hsize = 3'b010;
  logic [31:0] hwdata = 32'h0, hrdata, r;
  logic        rx_eof_stb = 1'b0, rx_frame_ok_stb = 1'b0, rx_busy = 1'b0;
  logic        bus_edge_stb = 1'b0, hreadyout, hresp, rx_bit_stb, rx_bit_val;
  logic        lost_arb_stb = 1'b0;
  logic        tx_bit_stb, tx_active, tx_bit_val, tx_drive_en, tx_underrun;
  logic        rx_keep_valid, cpu_irq, cpu_nmi;
  int          fails = 0, samples_checked = 0, cyc = 0;
  logic [7:0]  rx_tab [4] = '{8'h00, 8'hff, 8'ha5, 8'h3c};
  bdlbuf_core i_bdlbuf_core (.sys_clk(sys_clk), .resetn(resetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .rx_bit_stb(rx_bit_stb),
    .rx_bit_val(rx_bit_val), .rx_eof_stb(rx_eof_stb), .rx_ifr_stb(1'b0),
    .rx_frame_ok_stb(rx_frame_ok_stb), .rx_busy(rx_busy),
    .bus_edge_stb(bus_edge_stb), .lost_arb_stb(lost_arb_stb),
    .crc_err_stb(1'b0),
    .tx_bit_stb(tx_bit_stb), .tx_active(tx_active), .tx_bit_val(tx_bit_val),
    .tx_drive_en(tx_drive_en), .tx_underrun(tx_underrun),
    .rx_keep_valid(rx_keep_valid), .cpu_irq(cpu_irq), .cpu_nmi(cpu_nmi),
    .pwr_mode(pwr_mode));
  bdlbuf_node #(.GAP(8)) i_bdlbuf_node (.sys_clk(sys_clk), .resetn(resetn),
    .tx_active(tx_active), .tx_bit_val(tx_bit_val), .rx_bit_stb(rx_bit_stb),
    .rx_bit_val(rx_bit_val), .tx_bit_stb(tx_bit_stb));
  always #2 sys_clk = ~sys_clk;
  // hang guard, far above the several hundred cycles the run needs
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails++;
      end_of_test();
    end
  end
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, g);
    samples_checked++;
    if (g !== e) begin
      fails++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  // one single transfer; read data is taken at the data phase's edge
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'b10;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask
  task automatic rd(input logic [7:0] a, input string n, input logic [31:0] e);
    ahb(1'b0, a, 32'h0);
    chk(n, e, r);
  endtask
  // one-cycle strobe: 0 good frame, 1 end of frame, 2 bus edge, 3 lost arb
  task automatic pulse(input int k);
    rx_frame_ok_stb <= (k == 0);
    rx_eof_stb <= (k == 1);
    bus_edge_stb <= (k == 2);
    lost_arb_stb <= (k == 3);
    @(posedge sys_clk);
    {rx_frame_ok_stb, rx_eof_stb, bus_edge_stb, lost_arb_stb} <= 4'h0;
    repeat (3) @(posedge sys_clk);
  endtask
  task automatic wait_bits(input int n);
    for (int k = 0; k < 5000 && i_bdlbuf_node.tx_cnt_ff < n; k++) @(posedge sys_clk);
    repeat (2) @(posedge sys_clk);
  endtask
  initial begin
    repeat (10) @(posedge sys_clk);
    resetn <= 1'b1;
    @(posedge sys_clk);
    rd(`BDL_ADDR_SVEC, "vector reset", 32'h0);
    foreach (rx_tab[k]) begin
      i_bdlbuf_node.send_byte(rx_tab[k]);
      repeat (2) @(posedge sys_clk);
      rd(`BDL_ADDR_SVEC, "vector rx", 32'h0c);
      rd(`BDL_ADDR_DATA, "rx data", {24'h0, rx_tab[k]});
      rd(`BDL_ADDR_SVEC, "vector idle", 32'h0);
    end
    // unread byte is overwritten by the next one
    i_bdlbuf_node.send_byte(8'h11);
    i_bdlbuf_node.send_byte(8'h22);
    repeat (2) @(posedge sys_clk);
    rd(`BDL_ADDR_SVEC, "vector rx2", 32'h0c);
    rd(`BDL_ADDR_DATA, "rx overwrite", 32'h22);
    // two bytes then no refill: underrun, two pad ones, stop
    ahb(1'b1, `BDL_ADDR_DATA, 32'h96);
    rd(`BDL_ADDR_SVEC, "vector before bit", 32'h0);
    wait_bits(1);
    rd(`BDL_ADDR_SVEC, "vector tx empty", 32'h10);
    ahb(1'b1, `BDL_ADDR_DATA, 32'h5a);
    wait_bits(9);
    rd(`BDL_ADDR_SVEC, "vector refill", 32'h10);
    for (int k = 0; k < 5000 && tx_active !== 1'b0; k++) @(posedge sys_clk);
    chk("tx bits", 32'd18, i_bdlbuf_node.tx_cnt_ff);
    chk("tx tail", 32'h6b, {24'h0, i_bdlbuf_node.tx_seen_ff});
    chk("underrun", 32'h1, {31'h0, tx_underrun});
    rd(`BDL_ADDR_SVEC, "vector invalid", 32'h1c);
    rd(`BDL_ADDR_SVEC, "vector lower", 32'h10);
    ahb(1'b1, `BDL_ADDR_CTRL, 32'h4);
    rd(`BDL_ADDR_SVEC, "vector tx_end_of_data_request", 32'h0);
    // wait mode with interrupts enabled, woken by a good frame
    ahb(1'b1, `BDL_ADDR_CTRL, 32'h1);
    ahb(1'b1, `BDL_ADDR_PWR, 32'h1);
    rd(`BDL_ADDR_PWR, "wait mode", 32'h2);
    pulse(0);
    chk("irq wake", 32'h1, {31'h0, cpu_irq});
    rd(`BDL_ADDR_PWR, "woken", 32'h1);
    rd(`BDL_ADDR_SVEC, "vector wake", 32'h20);
    // wait with clock mode set goes to stop; eof seen first keeps data
    pulse(1);
    ahb(1'b1, `BDL_ADDR_CTRL, 32'h3);
    ahb(1'b1, `BDL_ADDR_PWR, 32'h1);
    rd(`BDL_ADDR_PWR, "wait to stop", 32'h4);
    chk("keep eof", 32'h1, {31'h0, rx_keep_valid});
    pulse(2);
    chk("nmi", 32'h1, {31'h0, cpu_nmi});
    rd(`BDL_ADDR_SVEC, "vector edge", 32'h20);
    rd(`BDL_ADDR_SVEC, "vector eof", 32'h04);
    pulse(3);
    rd(`BDL_ADDR_SVEC, "vector lost", 32'h14);
    rd(`BDL_ADDR_SVEC, "vector clear", 32'h0);
    // stop during reception, then a reset while woken
    ahb(1'b1, `BDL_ADDR_CTRL, 32'h0);
    rx_busy <= 1'b1;
    ahb(1'b1, `BDL_ADDR_PWR, 32'h2);
    rd(`BDL_ADDR_PWR, "stop mode", 32'h4);
    pulse(2);
    chk("keep lost", 32'h0, {31'h0, rx_keep_valid});
    chk("nmi rx", 32'h1, {31'h0, cpu_nmi});
    resetn <= 1'b0;
    rx_busy <= 1'b0;
    repeat (2) @(posedge sys_clk);
    resetn <= 1'b1;
    @(posedge sys_clk);
    chk("nmi reset", 32'h0, {31'h0, cpu_nmi});
    rd(`BDL_ADDR_PWR, "pwr reset", 32'h1);
    end_of_test();
  end
endmodule // test_bdlbuf_core
`default_nettype wire

/* File: verilog/bdlbuf_core.v */
// byte link controller data buffer, interrupt vector and power modes
// assumes: ahb-lite single word transfers, one slave; the symbol layer
// outside delivers one-cycle bit strobes for rx and tx and a passive-to-
// active edge pulse; all inputs synchronous to sys_clk
//
// The AHB-Lite slave port and the register addresses were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "bdlbuf_defs.vh"

// Notes on behaviour
// [RULE1] clearing top source leaves vector showing next lower pending source
// [RULE2] service code clears only the reported source, not every pending one
// [RULE3] data writes feed transmit bytes; reads give last received byte
// [RULE4] host writes next byte after tx empty, reads after rx full
// [RULE5] finished shift byte is replaced by the transmit shadow byte
// [RULE6] tx empty sets once first bit of loaded byte is sent
// [RULE7] complete rx byte copied to shadow, rx full flag set
// [RULE8] host has one byte time; next byte overwrites shadow regardless
// [RULE9] no new byte: flag underrun, send two extra ones, stop transmitter
// [RULE10] underrun abort seen by own receiver as invalid symbol error
// [RULE11] wait with wait-clock-mode clear enters wait; no bus drive there
// [RULE12] in wait a good message wakes and interrupts if enabled
// [RULE13] stop, or wait with wait-clock-mode set, enters stop mode
// [RULE14] in stop a passive-to-active edge wakes, raises nonmaskable request
// [RULE15] wait-entered stop keeps byte only if end-of-frame seen before
// [RULE16] stop during reception: first edge wakes at once, message not kept
// [RULE17] software ends transmissions before entering wait or stop
// [RULE18] rx flags clear by vector read then data read; tx by write or end
// [RULE19] vector codes 0c rx full, 10 tx empty, 1c invalid; higher wins
// [RULE20] vector reads 00 when idle; read clears non-data sources
// [RULE21] underrun when shift byte ends, shadow empty, no end request
module bdlbuf_core (
  input  wire        sys_clk,
  input  wire        resetn,
  input  wire        hsel,
  input  wire [7:0]  haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire        hready,
  input  wire [31:0] hwdata,
  output wire [31:0] hrdata,
  output wire        hreadyout,
  output wire        hresp,
  input  wire        rx_bit_stb,
  input  wire        rx_bit_val,
  input  wire        rx_eof_stb,
  input  wire        rx_ifr_stb,
  input  wire        rx_frame_ok_stb,
  input  wire        rx_busy,
  input  wire        bus_edge_stb,
  input  wire        lost_arb_stb,
  input  wire        crc_err_stb,
  input  wire        tx_bit_stb,
  output wire        tx_active,
  output wire        tx_bit_val,
  output wire        tx_drive_en,
  output wire        tx_underrun,
  output wire        rx_keep_valid,
  output wire        cpu_irq,
  output wire        cpu_nmi,
  output wire [1:0]  pwr_mode
);

  // power mode one-hot states
  localparam [2:0] PM_RUN  = 3'b001;
  localparam [2:0] PM_WAIT = 3'b010;
  localparam [2:0] PM_STOP = 3'b100;

  // ahb address phase capture
  reg        dph_ff;
  reg        dph_wr_ff;
  reg [7:0]  dph_addr_ff;
  wire       ap_take = hsel & hready & htrans[1];

  always @(posedge sys_clk) begin
    if (!resetn) begin
      dph_ff      <= 1'b0;
      dph_wr_ff   <= 1'b0;
      dph_addr_ff <= 8'h00;
    end else begin
      dph_ff      <= ap_take;
      dph_wr_ff   <= ap_take & hwrite;
      dph_addr_ff <= haddr;
    end
  end

  assign hreadyout = 1'b1;  // zero wait states
  assign hresp     = 1'b0;

  // write and read strobes in the data phase
  wire wr_data = dph_wr_ff & (dph_addr_ff == `BDL_ADDR_DATA);
  wire wr_ctrl = dph_wr_ff & (dph_addr_ff == `BDL_ADDR_CTRL);
  wire wr_pwr  = dph_wr_ff & (dph_addr_ff == `BDL_ADDR_PWR);
  wire rd_any  = dph_ff & ~dph_wr_ff;
  wire rd_data = rd_any & (dph_addr_ff == `BDL_ADDR_DATA);
  wire rd_svec = rd_any & (dph_addr_ff == `BDL_ADDR_SVEC);

  // control and status storage
  reg        ie_ff;
  reg        wcm_ff;
  reg        tx_end_of_data_request_ff;
  reg [7:0]  tx_shadow_ff;
  reg        tx_shadow_full_ff;
  reg [7:0]  tx_shift_ff;
  reg [3:0]  tx_cnt_ff;
  reg        tx_act_ff;
  reg [1:0]  pad_cnt_ff;
  reg        tx_empty_ff;
  reg        underrun_ff;
  reg [7:0]  rx_shift_ff;
  reg [3:0]  rx_cnt_ff;
  reg [7:0]  rx_shadow_ff;
  reg        rx_full_ff;
  reg        rx_ifr_ff;
  reg        eof_ff;
  reg        lost_ff;
  reg        crc_ff;
  reg        invalid_ff;
  reg        wake_ff;
  reg        sv_seen_ff;
  reg [2:0]  pm_ff;
  reg        stop_by_wait_ff;
  reg        eof_before_ff;
  reg        rx_at_stop_ff;
  reg        keep_ff;
  reg        irq_ff;
  reg        nmi_ff;
  reg [31:0] hrdata_ff;

  // vector: highest pending source wins, recomputed every cycle
  reg [7:0] sv_code;
  always @* begin
    sv_code = `BDL_SV_NONE;
    if (wake_ff)          sv_code = `BDL_SV_WAKE;     // see [RULE19]
    else if (invalid_ff)  sv_code = `BDL_SV_INVALID;
    else if (crc_ff)      sv_code = `BDL_SV_CRC;
    else if (lost_ff)     sv_code = `BDL_SV_LOSTARB;
    else if (tx_empty_ff) sv_code = `BDL_SV_TXEMPTY;
    else if (rx_full_ff)  sv_code = `BDL_SV_RXFULL;
    else if (rx_ifr_ff)   sv_code = `BDL_SV_RX_RESPONSE_BYTE_FLAG;
    else if (eof_ff)      sv_code = `BDL_SV_EOF;      // see [RULE1] [RULE20]
  end

  // a vector read clears only the source it reported, non-data ones
  wire clr_wake = rd_svec & (sv_code == `BDL_SV_WAKE);
  wire clr_inv  = rd_svec & (sv_code == `BDL_SV_INVALID);
  wire clr_crc  = rd_svec & (sv_code == `BDL_SV_CRC);
  wire clr_lost = rd_svec & (sv_code == `BDL_SV_LOSTARB);
  wire clr_eof  = rd_svec & (sv_code == `BDL_SV_EOF);   // see [RULE20]
  wire clr_rxd  = sv_seen_ff & rd_data;                 // see [RULE18]
  wire clr_txe  = (sv_seen_ff & wr_data) | (wr_ctrl & hwdata[`BDL_CTL_TX_END_OF_DATA_REQUEST]);

  // receive byte assembly
  wire rx_byte_done = rx_bit_stb & (rx_cnt_ff == `BDL_BYTE_BITS - 4'h1);
  // transmit end of byte and the underrun decision
  // count is zero at load, so the eighth strobe sees a count of seven
  wire tx_last   = tx_act_ff & tx_bit_stb &
                   (tx_cnt_ff == `BDL_BYTE_BITS - 4'h1);
  wire tx_first  = tx_act_ff & tx_bit_stb & (tx_cnt_ff == 4'h0);
  wire load_more = tx_last & tx_shadow_full_ff;
  wire urun_evt  = tx_last & ~tx_shadow_full_ff & ~tx_end_of_data_request_ff; // see [RULE21]
  wire drive_ok  = (pm_ff == PM_RUN);                       // see [RULE11]
  wire tx_start  = ~tx_act_ff & (pad_cnt_ff == 2'h0) & tx_shadow_full_ff &
                   drive_ok;
  wire wait_cmd  = wr_pwr & hwdata[`BDL_PWR_WAIT];
  wire stop_cmd  = wr_pwr & hwdata[`BDL_PWR_STOP];

  // main sequential state
  always @(posedge sys_clk) begin
    if (!resetn) begin
      ie_ff <= 1'b0;           wcm_ff <= 1'b0;          tx_end_of_data_request_ff <= 1'b0;
      tx_shadow_ff <= 8'h00;   tx_shadow_full_ff <= 1'b0;
      tx_shift_ff <= 8'h00;    tx_cnt_ff <= 4'h0;       tx_act_ff <= 1'b0;
      pad_cnt_ff <= 2'h0;      tx_empty_ff <= 1'b0;     underrun_ff <= 1'b0;
      rx_shift_ff <= 8'h00;    rx_cnt_ff <= 4'h0;       rx_shadow_ff <= 8'h00;
      rx_full_ff <= 1'b0;      rx_ifr_ff <= 1'b0;       eof_ff <= 1'b0;
      lost_ff <= 1'b0;         crc_ff <= 1'b0;          invalid_ff <= 1'b0;
      wake_ff <= 1'b0;         sv_seen_ff <= 1'b0;      pm_ff <= PM_RUN;
      stop_by_wait_ff <= 1'b0; eof_before_ff <= 1'b0;   rx_at_stop_ff <= 1'b0;
      keep_ff <= 1'b1;         irq_ff <= 1'b0;          nmi_ff <= 1'b0;
      hrdata_ff <= 32'h0000_0000;
    end else begin
      // control register
      if (wr_ctrl) begin
        ie_ff  <= hwdata[`BDL_CTL_IE];
        wcm_ff <= hwdata[`BDL_CTL_WCM];
      end
      // end-of-data request: held until a byte finishes with no shadow byte waiting
      if (wr_ctrl & hwdata[`BDL_CTL_TX_END_OF_DATA_REQUEST]) tx_end_of_data_request_ff <= 1'b1;
      else if (tx_last & ~tx_shadow_full_ff) tx_end_of_data_request_ff <= 1'b0;
      // vector read arms the data-servicing clears
      if (rd_svec) sv_seen_ff <= 1'b1;
      else if (rd_data | wr_data) sv_seen_ff <= 1'b0;

      // transmit shadow fill and move to shift register
      if (wr_data) begin
        tx_shadow_ff      <= hwdata[7:0];                 // see [RULE3]
        tx_shadow_full_ff <= 1'b1;
      end else if (tx_start | load_more) begin
        tx_shadow_full_ff <= 1'b0;
      end
      if (tx_start | load_more) begin
        tx_shift_ff <= tx_shadow_ff;                      // see [RULE5]
        tx_cnt_ff   <= 4'h0;
        tx_act_ff   <= 1'b1;
      end else if (tx_act_ff & tx_bit_stb) begin
        tx_shift_ff <= {tx_shift_ff[6:0], 1'b0};
        tx_cnt_ff   <= tx_cnt_ff + 4'h1;
        if (tx_last) tx_act_ff <= 1'b0;
      end
      // underrun: two logic ones then halt at a non-byte boundary
      if (urun_evt) pad_cnt_ff <= `BDL_PAD_BITS;          // see [RULE9]
      else if (tx_bit_stb & (pad_cnt_ff != 2'h0))
        pad_cnt_ff <= pad_cnt_ff - 2'h1;
      if (urun_evt) underrun_ff <= 1'b1;
      else if (tx_start) underrun_ff <= 1'b0;

      // tx empty flag: set wins over clear
      if (tx_first) tx_empty_ff <= 1'b1;                  // see [RULE6]
      else if (clr_txe) tx_empty_ff <= 1'b0;              // see [RULE18]

      // receive shift and shadow copy
      if (rx_bit_stb) begin
        rx_shift_ff <= {rx_shift_ff[6:0], rx_bit_val};
        rx_cnt_ff   <= rx_byte_done ? 4'h0 : rx_cnt_ff + 4'h1;
      end
      if (rx_eof_stb) rx_cnt_ff <= 4'h0;
      if (rx_byte_done)                                   // see [RULE8]
        rx_shadow_ff <= {rx_shift_ff[6:0], rx_bit_val};   // see [RULE7]
      if (rx_byte_done & ~rx_ifr_stb) rx_full_ff <= 1'b1;
      else if (clr_rxd) rx_full_ff <= 1'b0;
      if (rx_byte_done & rx_ifr_stb) rx_ifr_ff <= 1'b1;
      else if (clr_rxd) rx_ifr_ff <= 1'b0;

      // other sources, set wins over vector-read clear
      if (rx_eof_stb) eof_ff <= 1'b1;
      else if (clr_eof) eof_ff <= 1'b0;
      if (lost_arb_stb) lost_ff <= 1'b1;
      else if (clr_lost) lost_ff <= 1'b0;
      if (crc_err_stb) crc_ff <= 1'b1;
      else if (clr_crc) crc_ff <= 1'b0;
      if (urun_evt) invalid_ff <= 1'b1;                   // see [RULE10]
      else if (clr_inv) invalid_ff <= 1'b0;

      // power modes
      case (pm_ff)
        PM_RUN: begin
          if (stop_cmd | (wait_cmd & wcm_ff)) begin       // see [RULE13]
            pm_ff           <= PM_STOP;
            stop_by_wait_ff <= ~stop_cmd & wait_cmd;
            rx_at_stop_ff   <= rx_busy;
            eof_before_ff   <= eof_ff | rx_eof_stb;
          end else if (wait_cmd) begin
            pm_ff <= PM_WAIT;                             // see [RULE11]
          end
        end
        PM_WAIT: begin
          if (rx_frame_ok_stb) begin                      // see [RULE12]
            pm_ff   <= PM_RUN;
            wake_ff <= 1'b1;
          end
        end
        PM_STOP: begin
          if (bus_edge_stb) begin                         // see [RULE14]
            pm_ff   <= PM_RUN;
            wake_ff <= 1'b1;
            nmi_ff  <= 1'b1;
            // see [RULE15] [RULE16]
            keep_ff <= stop_by_wait_ff & eof_before_ff & ~rx_at_stop_ff;
          end
        end
        default: pm_ff <= PM_RUN;
      endcase
      if (clr_wake & ~(bus_edge_stb & pm_ff[2])) begin
        wake_ff <= 1'b0;
        nmi_ff  <= 1'b0;
      end
      if (rx_eof_stb & pm_ff[0]) keep_ff <= 1'b1;
      irq_ff <= ie_ff & (sv_code != `BDL_SV_NONE) & ~nmi_ff;

      // read data registered for the next data phase
      if (ap_take & ~hwrite) begin
        if (haddr == `BDL_ADDR_DATA)
          hrdata_ff <= {24'h000000, rx_shadow_ff};        // see [RULE3]
        else if (haddr == `BDL_ADDR_SVEC)
          hrdata_ff <= {24'h000000, sv_code};
        else if (haddr == `BDL_ADDR_CTRL)
          hrdata_ff <= {29'h0, tx_end_of_data_request_ff, wcm_ff, ie_ff};
        else if (haddr == `BDL_ADDR_STAT)
          hrdata_ff <= {26'h0, keep_ff, underrun_ff, tx_shadow_full_ff,
                        tx_act_ff, rx_full_ff, tx_empty_ff};
        else if (haddr == `BDL_ADDR_PWR)
          hrdata_ff <= {29'h0, pm_ff};
        else
          hrdata_ff <= 32'h0000_0000;
      end
    end
  end

  // the vector read happens in the data phase, after hrdata was latched;
  // software therefore sees the code as it stood at the address phase
  assign hrdata        = hrdata_ff;
  assign tx_active     = tx_act_ff | (pad_cnt_ff != 2'h0);
  assign tx_bit_val    = (pad_cnt_ff != 2'h0) | tx_shift_ff[7]; // ones pad
  assign tx_drive_en   = tx_active & drive_ok;            // see [RULE11]
  assign tx_underrun   = underrun_ff;
  assign rx_keep_valid = keep_ff;
  assign cpu_irq       = irq_ff;
  assign cpu_nmi       = nmi_ff;
  assign pwr_mode      = {pm_ff[2], pm_ff[1]};

endmodule // bdlbuf_core
`default_nettype wire
